//--- hdl/fse_defines.vh
`ifndef FSE_DEFINES_VH
`define FSE_DEFINES_VH

// command codes
`define FSE_CMD_ERASE_SECTOR 8'h0A
`define FSE_CMD_UNSECURE 8'h0B

// parameter indices
`define FSE_IDX_0 3'h0
`define FSE_IDX_1 3'h1

// field positions inside parameter word 0
`define FSE_W0_CMD_HI 15
`define FSE_W0_CMD_LO 8
`define FSE_W0_BLK_HI 1
`define FSE_W0_BLK_LO 0

// phrase alignment bits of the low address word
`define FSE_ALIGN_HI 2
`define FSE_ALIGN_LO 0

// reset values
`define FSE_CMD_COMPLETE_FLAG_RST 1'b1
`define FSE_SECURE_RST 1'b1

// timing: erase and verify durations in microseconds, clock 40 MHz
`define FSE_CLK_MHZ 40
`define FSE_ERASE_US 20
`define FSE_VERIFY_US 5
`define FSE_ERASE_CYC (`FSE_ERASE_US * `FSE_CLK_MHZ)
`define FSE_VERIFY_CYC (`FSE_VERIFY_US * `FSE_CLK_MHZ)

`endif

//--- hdl/fse_timer.v
`timescale 1ns/1ps
`include "fse_defines.vh"

// one-shot down counter; done_out pulses one cycle when the count runs out
module fse_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire ref_clk_in,
    input wire resetn_in,
    // control
    input wire start_in,
    input wire [WIDTH-1:0] load_in,
    // status
    output reg busy_out,
    output reg done_out
);
    reg [WIDTH-1:0] count_q;

    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_q <= {WIDTH{1'b0}};
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                count_q <= load_in;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

//--- hdl/fse_sequencer.v
`timescale 1ns/1ps
`include "fse_defines.vh"

module fse_sequencer #(
    parameter NUM_BLOCKS = 1,
    parameter ERASE_CYCLES = `FSE_ERASE_CYC,
    parameter VERIFY_CYCLES = `FSE_VERIFY_CYC,
    parameter SECTOR_BITS = 9
) (
    // clock and reset
    input wire ref_clk_in,
    input wire resetn_in,
    // command parameter loading
    input wire param_wr_in,
    input wire [2:0] cmd_param_index_in,
    input wire [15:0] cmd_param_word_in,
    // launch: a write of one to the flag clears it
    input wire cmd_complete_flag_clear_in,
    // status flag clear, write one to clear
    input wire access_error_clr_in,
    input wire protection_violation_clr_in,
    // mode and protection
    input wire cmd_allowed_in,
    input wire sector_protected_in,
    // flash array handshake
    input wire verify_fail_in,
    input wire verify_uncorrectable_in,
    // status
    output reg cmd_complete_flag_out,
    output reg access_error_flag_out,
    output reg protection_violation_flag_out,
    output reg verify_error_flag_out,
    output reg verify_uncorrectable_flag_out,
    output reg secure_out,
    // array control
    output reg sector_erase_out,
    output reg mass_erase_out,
    output reg verify_out,
    output reg [17:0] erase_addr_out
);
    localparam S_IDLE = 5'b00001;
    localparam S_CHECK = 5'b00010;
    localparam S_ERASE = 5'b00100;
    localparam S_VERIFY = 5'b01000;
    localparam S_DONE = 5'b10000;
    localparam TW = 16;

    reg [4:0] state_q;
    reg [15:0] word_q [0:1];
    reg [2:0] index_q;
    reg is_unsecure_q;
    reg tmr_start_q;
    reg [TW-1:0] tmr_load_q;
    wire tmr_busy;
    wire tmr_done;

    wire [7:0] cmd_code = word_q[0][`FSE_W0_CMD_HI:`FSE_W0_CMD_LO];
    wire [1:0] blk_sel = word_q[0][`FSE_W0_BLK_HI:`FSE_W0_BLK_LO];

    // block bits select a program flash block only below NUM_BLOCKS
    function blk_valid;
        input [1:0] sel;
        begin
            blk_valid = ({30'h0000_0000, sel} < NUM_BLOCKS);
        end
    endfunction

    // parameter words stored by index; index register tracks last write
    // software must not write during a command, so writes are ignored then
    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_q[0] <= 16'h0000;
            word_q[1] <= 16'h0000;
            index_q <= 3'h0;
        end else if (param_wr_in && cmd_complete_flag_out) begin
            index_q <= cmd_param_index_in;
            if (cmd_param_index_in == `FSE_IDX_0)
                word_q[0] <= cmd_param_word_in;
            else if (cmd_param_index_in == `FSE_IDX_1)
                word_q[1] <= cmd_param_word_in;
        end
    end

    fse_timer #(
        .WIDTH(TW)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .start_in(tmr_start_q),
        .load_in(tmr_load_q),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    always @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= S_IDLE;
            is_unsecure_q <= 1'b0;
            tmr_start_q <= 1'b0;
            tmr_load_q <= {TW{1'b0}};
            cmd_complete_flag_out <= `FSE_CMD_COMPLETE_FLAG_RST;
            access_error_flag_out <= 1'b0;
            protection_violation_flag_out <= 1'b0;
            verify_error_flag_out <= 1'b0;
            verify_uncorrectable_flag_out <= 1'b0;
            secure_out <= `FSE_SECURE_RST;
            sector_erase_out <= 1'b0;
            mass_erase_out <= 1'b0;
            verify_out <= 1'b0;
            erase_addr_out <= 18'h0_0000;
        end else begin
            tmr_start_q <= 1'b0;
            // error flags: clear only when idle, so a new error always wins
            if (access_error_clr_in && state_q == S_IDLE)
                access_error_flag_out <= 1'b0;
            if (protection_violation_clr_in && state_q == S_IDLE)
                protection_violation_flag_out <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    // launch blocked while old access or protection error flags stand
                    if (cmd_complete_flag_clear_in && cmd_complete_flag_out &&
                        !access_error_flag_out && !protection_violation_flag_out) begin
                        cmd_complete_flag_out <= 1'b0;
                        verify_error_flag_out <= 1'b0;
                        verify_uncorrectable_flag_out <= 1'b0;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (cmd_code == `FSE_CMD_ERASE_SECTOR) begin
                        erase_addr_out <= {blk_sel, word_q[1]};
                        if (index_q != `FSE_IDX_1 || !cmd_allowed_in ||
                            !blk_valid(blk_sel) ||
                            word_q[1][`FSE_ALIGN_HI:`FSE_ALIGN_LO] != 3'h0) begin
                            access_error_flag_out <= 1'b1;
                            state_q <= S_DONE;
                        end else if (sector_protected_in) begin
                            protection_violation_flag_out <= 1'b1;
                            state_q <= S_DONE;
                        end else begin
                            is_unsecure_q <= 1'b0;
                            sector_erase_out <= 1'b1;
                            tmr_load_q <= ERASE_CYCLES[TW-1:0];
                            tmr_start_q <= 1'b1;
                            state_q <= S_ERASE;
                        end
                    end else if (cmd_code == `FSE_CMD_UNSECURE && cmd_allowed_in) begin
                        is_unsecure_q <= 1'b1;
                        mass_erase_out <= 1'b1;
                        tmr_load_q <= ERASE_CYCLES[TW-1:0];
                        tmr_start_q <= 1'b1;
                        state_q <= S_ERASE;
                    end else begin
                        // unknown code or unsecure refused in this mode
                        access_error_flag_out <= 1'b1;
                        state_q <= S_DONE;
                    end
                end
                S_ERASE: begin
                    if (tmr_done) begin
                        sector_erase_out <= 1'b0;
                        mass_erase_out <= 1'b0;
                        verify_out <= 1'b1;
                        tmr_load_q <= VERIFY_CYCLES[TW-1:0];
                        tmr_start_q <= 1'b1;
                        state_q <= S_VERIFY;
                    end
                end
                S_VERIFY: begin
                    // fail inputs sampled through the whole verify window; uncorrectable only when not an unsecure erase
                    if (verify_out && verify_fail_in)
                        verify_error_flag_out <= 1'b1;
                    if (verify_out && verify_uncorrectable_in && !is_unsecure_q)
                        verify_uncorrectable_flag_out <= 1'b1;
                    if (tmr_done) begin
                        verify_out <= 1'b0;
                        if (is_unsecure_q && !verify_error_flag_out && !verify_fail_in)
                            secure_out <= 1'b0;
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    cmd_complete_flag_out <= 1'b1;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // timer busy is a redundant view of the erase and verify states
    wire unused_busy = tmr_busy;
endmodule

//--- verification/fse_seq_monitor.sv
`timescale 1ns/1ps
module fse_seq_monitor (
    // clock and reset
    input wire ref_clk_in,
    input wire resetn_in,
    // launch
    input wire cmd_complete_flag_clear_in,
    // status and array control
    input wire cmd_complete_flag_out,
    input wire access_error_flag_out,
    input wire protection_violation_flag_out,
    input wire verify_error_flag_out,
    input wire verify_uncorrectable_flag_out,
    input wire secure_out,
    input wire sector_erase_out,
    input wire mass_erase_out,
    input wire verify_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);
    wire errs = access_error_flag_out || protection_violation_flag_out;
    a_launch_drops_flag: assert property (
        cmd_complete_flag_clear_in && cmd_complete_flag_out && !errs |=> !cmd_complete_flag_out)
        else $error("launch left flag set");
    a_err_done_fast: assert property ($rose(errs) |-> ##[0:2] cmd_complete_flag_out)
        else $error("error launch not finished");
    a_err_no_erase: assert property (
        errs |-> !sector_erase_out && !mass_erase_out)
        else $error("erase despite error");
    a_sector_only: assert property (
        sector_erase_out |-> !mass_erase_out && !verify_out && !cmd_complete_flag_out)
        else $error("sector erase overlap");
    a_sector_verify: assert property ($fell(sector_erase_out) |-> ##[0:2] verify_out)
        else $error("no verify after sector erase");
    a_mass_verify: assert property ($fell(mass_erase_out) |-> ##[0:2] verify_out)
        else $error("no verify after mass erase");
    a_verify_end_flag: assert property (
        $fell(verify_out) |-> ##[0:2] cmd_complete_flag_out)
        else $error("flag late after verify");
    a_secure_needs_pass: assert property (
        $fell(secure_out) |-> !verify_error_flag_out && $past(verify_out))
        else $error("security released wrongly");
    a_verr_in_verify: assert property ($rose(verify_error_flag_out) |-> $past(verify_out))
        else $error("verify error outside verify");
    a_unc_in_verify: assert property (
        $rose(verify_uncorrectable_flag_out) |-> $past(verify_out))
        else $error("uncorrectable outside verify");
    c_sector: cover property ($fell(sector_erase_out));
    c_unsecure: cover property ($fell(secure_out));
    c_err: cover property ($rose(access_error_flag_out));
endmodule
bind fse_sequencer fse_seq_monitor mon_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .cmd_complete_flag_clear_in(cmd_complete_flag_clear_in), .cmd_complete_flag_out(cmd_complete_flag_out),
    .access_error_flag_out(access_error_flag_out), .secure_out(secure_out),
    .protection_violation_flag_out(protection_violation_flag_out),
    .verify_error_flag_out(verify_error_flag_out), .verify_out(verify_out),
    .verify_uncorrectable_flag_out(verify_uncorrectable_flag_out),
    .sector_erase_out(sector_erase_out), .mass_erase_out(mass_erase_out));

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg wr_en = 1'b0;
    reg [2:0] idx = 3'h0;
    reg [15:0] word = 16'h0000;
    reg go = 1'b0;
    reg clr = 1'b0;
    reg ok = 1'b1;
    reg pr = 1'b0;
    reg vf = 1'b0;
    reg vu = 1'b0;
    wire done, acc, prot, verr, vunc, sec, se_o, me_o, vo;
    wire [17:0] addr;
    integer fail_count = 0;
    integer checked = 0;
    integer cycles = 0;
    integer n;
    reg [4:0] exp_q[$];
    reg [15:0] a;
    always #12.5 clk = ~clk;
    // short counts keep the run brief; figures below assume erase 4, verify 3
    fse_sequencer #(.ERASE_CYCLES(4), .VERIFY_CYCLES(3)) dut_u (.ref_clk_in(clk),
        .resetn_in(rst_n), .param_wr_in(wr_en), .cmd_param_index_in(idx),
        .cmd_param_word_in(word), .cmd_complete_flag_clear_in(go), .access_error_clr_in(clr),
        .protection_violation_clr_in(clr), .cmd_allowed_in(ok), .sector_protected_in(pr),
        .verify_fail_in(vf), .verify_uncorrectable_in(vu), .cmd_complete_flag_out(done),
        .access_error_flag_out(acc), .protection_violation_flag_out(prot),
        .verify_error_flag_out(verr), .verify_uncorrectable_flag_out(vunc),
        .secure_out(sec), .sector_erase_out(se_o), .mass_erase_out(me_o),
        .verify_out(vo), .erase_addr_out(addr));
    task chk(input [17:0] seen, input [17:0] want);
        begin
            checked = checked + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checked %0d fail_count %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task wr(input [2:0] i, input [15:0] w);
        begin
            @(negedge clk);
            wr_en = 1'b1;
            idx = i;
            word = w;
            @(negedge clk);
            wr_en = 1'b0;
        end
    endtask
    // expected flags {access, protect, verify, uncorrectable, secure}
    task run(input [4:0] x);
        begin
            exp_q.push_back(x);
            @(negedge clk);
            go = 1'b1;
            @(negedge clk);
            go = 1'b0;
            @(negedge clk);
            chk(done, 1'b0);
            // nothing else is written while busy
            for (n = 0; n < 60 && done !== 1'b1; n = n + 1)
                @(negedge clk);
            chk(n < 60, 1'b1);
            @(negedge clk);
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
        end
    endtask
    task se(input [1:0] blk, input [15:0] lo, input [2:0] li);
        begin
            wr(3'h0, {8'h0A, 6'h00, blk});
            wr(3'h1, lo);
            // index 3 is not stored, so only the index moves
            if (li != 3'h1)
                wr(li, {8'h0A, 6'h00, blk});
        end
    endtask
    always @(posedge done) begin
        #1;
        if (exp_q.size() > 0)
            chk({acc, prot, verr, vunc, sec}, exp_q.pop_front());
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end
    initial begin
        a = $urandom(32'h81FA);
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk({done, acc, prot, verr, vunc, sec}, 6'h21);
        a = $urandom;
        a[2:0] = 3'h0;
        se(2'h0, a, 3'h1);
        run(5'h01);
        chk(addr, {2'h0, a});
        se(2'h0, a, 3'h3);
        run(5'h11);
        se(2'h0, a, 3'h0);
        run(5'h11);
        ok = 1'b0;
        se(2'h0, a, 3'h1);
        run(5'h11);
        ok = 1'b1;
        se(2'h1 + $urandom % 3, a, 3'h1);
        run(5'h11);
        se(2'h0, {a[15:3], 3'h5}, 3'h1);
        run(5'h11);
        pr = 1'b1;
        se(2'h0, a, 3'h1);
        run(5'h09);
        pr = 1'b0;
        vf = 1'b1;
        se(2'h0, a, 3'h1);
        run(5'h05);
        vu = 1'b1;
        se(2'h0, a, 3'h1);
        run(5'h07);
        vu = 1'b0;
        // a failed blank check must keep the part secured
        wr(3'h0, 16'h0B00);
        run(5'h05);
        vf = 1'b0;
        a = $urandom;
        wr(3'h0, {4'h1, a[3:0], 8'h00});
        run(5'h11);
        wr(3'h0, 16'h0B00);
        run(5'h00);
        print_verdict;
    end
endmodule
